// File: ethv_pkg.sv
/*
 package for the edge triggered value hold array: sizes, reset values and
 per-element configuration layout. assumes nothing of its surroundings.
*/
package ethv_pkg;
   localparam int          NUM_ELEM      = 32;
   localparam int          VAL_W         = 32;
   localparam int          RETAIN_BYTES  = 4;
   localparam int          IDX_W         = 5;
   localparam logic [31:0] VAL_RST       = 32'h0000_0000;
   localparam logic        CONFIRM_RST   = 1'b0;
   localparam logic [31:0] APB_ADDR_W    = 32'h0000_000c;
   // register byte addresses
   localparam logic [11:0] OFS_EN_GATE   = 12'h000;
   localparam logic [11:0] OFS_NO_EDGE   = 12'h004;
   localparam logic [11:0] OFS_RETAIN    = 12'h008;
   localparam logic [11:0] OFS_CONFIRM   = 12'h00c;
   localparam logic [11:0] OFS_VALUE_LO  = 12'h100;
   localparam logic [11:0] OFS_VALUE_HI  = 12'h17c;
   localparam logic [31:0] EN_GATE_RST   = 32'h0000_0000;
   localparam logic [31:0] NO_EDGE_RST   = 32'h0000_0000;
   localparam logic [31:0] RETAIN_RST    = 32'h0000_0000;
   typedef enum logic [1:0] {ETHV_STOP, ETHV_RESTORE, ETHV_RUN} ethv_mode_t;
endpackage : ethv_pkg

// File: ethv_store.sv
/*
 retained value store: one 32-bit word (four bytes) per element, registered
 read port. assumes the caller gives one write and one read per cycle.
*/
`timescale 1ns/1ps
module ethv_store #(
   parameter int DEPTH = 32,
   parameter int W     = 32,
   parameter int AW    = 5
) (
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [W-1:0]  wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [W-1:0]  rdata
);
   // not reset: contents model storage that outlives a power loss
   logic [W-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      rdata <= mem[raddr];
   end
endmodule : ethv_store

// File: ethv_top.sv
/*
 edge triggered value hold array: thirty-two elements, each copies its value
 input to its held output on a rising trigger, confirms while the trigger is
 high, can be gated by an activation input and can retain its value.
 assumes one program scan per clk edge, trigger/value/activation from logic
 on the same clock, software configuration over APB.
*/
`timescale 1ns/1ps
module ethv_top #(
   parameter int N = ethv_pkg::NUM_ELEM,
   parameter int W = ethv_pkg::VAL_W
) (
   input  wire logic                 clk,
   input  wire logic                 rstn,
   input  wire logic                 run_mode,
   input  wire logic [N-1:0]         trigger,
   input  wire logic [N-1:0]         activate,
   input  wire logic [N*W-1:0]       value_input,
   output logic      [N*W-1:0]       value_output,
   output logic      [N-1:0]         transfer_confirm,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr
);
   localparam int AW = ethv_pkg::IDX_W;

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers

   logic [N-1:0] en_gate_r;
   logic [N-1:0] no_edge_r;
   logic [N-1:0] retain_r;
   logic         wr_acc;
   logic         rd_acc;

   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == ethv_pkg::OFS_EN_GATE) || (a == ethv_pkg::OFS_NO_EDGE) ||
               (a == ethv_pkg::OFS_RETAIN) || (a == ethv_pkg::OFS_CONFIRM) ||
               (a >= ethv_pkg::OFS_VALUE_LO && a <= ethv_pkg::OFS_VALUE_HI &&
                a[1:0] == 2'b00);
   endfunction : mapped

   // slave answers in the first access cycle, so pready is the flop of setup
   assign wr_acc = psel && penable && pready && pwrite;
   assign rd_acc = psel && !penable && !pwrite;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         en_gate_r <= N'(ethv_pkg::EN_GATE_RST);
         no_edge_r <= N'(ethv_pkg::NO_EDGE_RST);
         retain_r  <= N'(ethv_pkg::RETAIN_RST);
      end else if (wr_acc) begin
         case (paddr)
            ethv_pkg::OFS_EN_GATE: en_gate_r <= pwdata[N-1:0];
            ethv_pkg::OFS_NO_EDGE: no_edge_r <= pwdata[N-1:0];
            ethv_pkg::OFS_RETAIN:  retain_r  <= pwdata[N-1:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // run/stop sequencing and restore walk

   ethv_pkg::ethv_mode_t mode_r;
   logic [AW-1:0]        rst_idx_r;
   logic                 rst_vld_r;
   logic [AW-1:0]        rst_widx_r;
   logic [W-1:0]         store_rdata;
   logic                 running;

   // restore reads one word per cycle; data appears one cycle after the read
   always_ff @(posedge clk) begin
      if (!rstn) begin
         mode_r     <= ethv_pkg::ETHV_STOP;
         rst_idx_r  <= '0;
         rst_vld_r  <= 1'b0;
         rst_widx_r <= '0;
      end else begin
         rst_vld_r  <= (mode_r == ethv_pkg::ETHV_RESTORE);
         rst_widx_r <= rst_idx_r;
         case (mode_r)
            ethv_pkg::ETHV_STOP: begin
               rst_idx_r <= '0;
               if (run_mode) begin
                  mode_r <= ethv_pkg::ETHV_RESTORE;
               end
            end
            ethv_pkg::ETHV_RESTORE: begin
               rst_idx_r <= rst_idx_r + 1'b1;
               if (rst_idx_r == AW'(N - 1)) begin
                  mode_r <= ethv_pkg::ETHV_RUN;
               end
            end
            ethv_pkg::ETHV_RUN: begin
               if (!run_mode) begin
                  mode_r <= ethv_pkg::ETHV_STOP;
               end
            end
            default: mode_r <= ethv_pkg::ETHV_STOP;
         endcase
      end
   end

   // the last restored word lands in the first run cycle; triggers in that
   // cycle are still honoured because a transfer takes priority over the restore write
   assign running = (mode_r == ethv_pkg::ETHV_RUN);

   ////////////////////////////////////////////////////////////////////////////
   // elements

   logic [N-1:0] trig_d_r;
   logic [N-1:0] fire;
   logic [AW-1:0] wr_idx;
   logic          wr_en;
   logic [W-1:0]  wr_val;

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_elem
         logic active;
         logic edge_seen;
         assign active    = !en_gate_r[g] || activate[g];
         assign edge_seen = no_edge_r[g] ? trigger[g]
                                         : (trigger[g] && !trig_d_r[g]);
         assign fire[g]   = running && active && edge_seen;

         always_ff @(posedge clk) begin
            if (!rstn) begin
               trig_d_r[g] <= 1'b0;
            end else if (running) begin
               trig_d_r[g] <= trigger[g];
            end
         end

         // held value: written on a transfer or by restore, otherwise kept
         always_ff @(posedge clk) begin
            if (!rstn) begin
               value_output[g*W +: W] <= ethv_pkg::VAL_RST;
            end else if (fire[g]) begin
               value_output[g*W +: W] <= value_input[g*W +: W];
            end else if (rst_vld_r && rst_widx_r == AW'(g) && retain_r[g]) begin
               value_output[g*W +: W] <= store_rdata;
            end
         end

         always_ff @(posedge clk) begin
            if (!rstn) begin
               transfer_confirm[g] <= ethv_pkg::CONFIRM_RST;
            end else if (!running || !trigger[g] || !active) begin
               transfer_confirm[g] <= 1'b0;
            end else if (fire[g]) begin
               transfer_confirm[g] <= 1'b1;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // non-volatile copy: lowest firing retentive element written per cycle

   always_comb begin
      wr_en  = 1'b0;
      wr_idx = '0;
      wr_val = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (fire[i] && retain_r[i]) begin
            wr_en  = 1'b1;
            wr_idx = AW'(i);
            wr_val = value_input[i*W +: W];
         end
      end
   end

   // limitation: only one store write per scan; other simultaneous retentive
   // transfers are mirrored on the next run when they fire again
   ethv_store #(
      .DEPTH (N),
      .W     (W),
      .AW    (AW)
   ) u_store (
      .clk   (clk),
      .we    (wr_en),
      .waddr (wr_idx),
      .wdata (wr_val),
      .raddr (rst_idx_r),
      .rdata (store_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // apb read path

   logic [31:0] rd_nxt;
   logic [AW-1:0] vidx;
   assign vidx = paddr[AW+1:2];

   always_comb begin
      rd_nxt = 32'h0000_0000;
      case (paddr)
         ethv_pkg::OFS_EN_GATE: rd_nxt = 32'(en_gate_r);
         ethv_pkg::OFS_NO_EDGE: rd_nxt = 32'(no_edge_r);
         ethv_pkg::OFS_RETAIN:  rd_nxt = 32'(retain_r);
         ethv_pkg::OFS_CONFIRM: rd_nxt = 32'(transfer_confirm);
         default: begin
            if (mapped(paddr) && paddr >= ethv_pkg::OFS_VALUE_LO) begin
               rd_nxt = value_output[vidx*W +: W];
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped(paddr);
         if (rd_acc) begin
            prdata <= rd_nxt;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   property p_hold(int i);
      @(posedge clk) disable iff (!rstn)
      !fire[i] && !rst_vld_r |=> $stable(value_output[i*W +: W]);
   endproperty
   property p_copy(int i);
      @(posedge clk) disable iff (!rstn)
      fire[i] |=> value_output[i*W +: W] == $past(value_input[i*W +: W]);
   endproperty
   // the edge detector only samples while running, so both cycles must be in RUN
   sequence s_rise0;
      running && !trigger[0] ##1 running && trigger[0];
   endsequence

   a_hold_value:    assert property (p_hold(0)) else $error("held value changed");
   a_copy_value:    assert property (p_copy(0)) else $error("copy wrong");
   a_copy_last:     assert property (p_copy(N-1)) else $error("copy wrong");
   a_edge_once:     assert property (@(posedge clk) disable iff (!rstn)
      fire[0] && !no_edge_r[0] |=> !fire[0]) else $error("fired twice");
   a_gate_block:    assert property (@(posedge clk) disable iff (!rstn)
      en_gate_r[0] && !activate[0] |-> !fire[0]) else $error("fired inactive");
   a_gate_off:      assert property (@(posedge clk) disable iff (!rstn)
      s_rise0 ##0 (!en_gate_r[0] && !no_edge_r[0]) |-> fire[0])
      else $error("ungated missed");
   a_confirm_trig:  assert property (@(posedge clk) disable iff (!rstn)
      transfer_confirm[0] |-> $past(trigger[0])) else $error("confirm no trig");
   a_confirm_set:   assert property (@(posedge clk) disable iff (!rstn)
      fire[0] |=> transfer_confirm[0]) else $error("confirm missing");
   // every element at once: an ungated level-mode slot held high must fire each cycle
   a_level_fire:    assert property (@(posedge clk) disable iff (!rstn)
      running |-> (trigger & no_edge_r & ~en_gate_r & ~fire) == '0)
      else $error("level missed");
   a_restore_len:   assert property (@(posedge clk) disable iff (!rstn)
      mode_r == ethv_pkg::ETHV_STOP && run_mode |=> ##32 running)
      else $error("restore length");
   a_store_write:   assert property (@(posedge clk) disable iff (!rstn)
      (fire & retain_r) != '0 |-> wr_en && fire[wr_idx] && retain_r[wr_idx])
      else $error("no retain write");
   a_reset_zero:    assert property (@(posedge clk)
      !rstn |=> value_output == '0 && transfer_confirm == '0)
      else $error("reset values");
endmodule : ethv_top

// File: ethv_prog.sv
/*
 program-side model for the value hold array: drives triggers, activations
 and values. assumes its tasks are called right after a rising clk edge.
*/
`timescale 1ns/1ps
module ethv_prog (
   input  wire logic          clk,
   output logic      [31:0]   trigger,
   output logic      [31:0]   activate,
   output logic      [1023:0] value_input
);
   logic [31:0]   busy_r;
   logic [1023:0] held_r;
   logic [1023:0] noise_r;

   initial begin
      trigger = '0;
      activate = '0;
      busy_r = '0;
      held_r = '0;
      noise_r = {32{32'h5a3c_96e1}};
   end

   // an idle value moves every scan, so a stale copy never looks held
   always @(posedge clk) noise_r <= {noise_r[1022:0], ~noise_r[1023]};
   always_comb
      for (int i = 0; i < 32; i++)
         value_input[i*32+:32] = busy_r[i] ? held_r[i*32+:32] : noise_r[i*32+:32];

   task fire(input int i, input logic [31:0] v, input int hold);
      trigger[i] <= 1'b1;
      held_r[i*32+:32] <= v;
      busy_r[i] <= 1'b1;
      repeat (hold) @(posedge clk);
      trigger[i] <= 1'b0;
      busy_r[i] <= 1'b0;
   endtask : fire

   task hold(input int i, input logic t, input logic a);
      trigger[i] <= t;
      activate[i] <= a;
   endtask : hold
endmodule : ethv_prog

// File: tb_edge_triggered_value_hold.sv
/*
 self-checking bench for the value hold array: a program model drives the
 elements, an APB master the registers. assumes the design and ethv_prog.
*/
`timescale 1ns/1ps
module tb_edge_triggered_value_hold;
   logic          clk, rstn, run_mode, psel, penable, pwrite, pready, pslverr, er;
   logic [11:0]   paddr;
   logic [31:0]   pwdata, prdata, rd, v, v0, prev_conf, trigger, activate, transfer_confirm;
   logic [36:0]   e;
   logic [1023:0] value_input, value_output;
   logic [31:0]   vals [32];
   logic [36:0]   exp_q [$];
   int            miscompares, n_compared, seed, cyc;

   ethv_top dut (.clk(clk), .rstn(rstn), .run_mode(run_mode), .trigger(trigger),
      .activate(activate), .value_input(value_input), .value_output(value_output),
      .transfer_confirm(transfer_confirm), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   ethv_prog prog (.clk(clk), .trigger(trigger), .activate(activate), .value_input(value_input));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   function automatic logic [31:0] vi(input int i);
      return value_input[i*32+:32];
   endfunction : vi

   function automatic logic [31:0] vo(input int i);
      return value_output[i*32+:32];
   endfunction : vo

   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      n_compared++;
      if (g !== x) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, x, g);
      end
   endtask : chk

   task automatic print_verdict;
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // only the bench timeout ends a wait for pready
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge, so the next call never re-drives psel in this step
      @(posedge clk);
   endtask : apb

   task automatic level_run(input int i, input logic follow);
      prog.hold(i, 1'b1, 1'b0);
      @(negedge clk);
      v0 = vi(i);
      exp_q.push_back({5'(i), v0});
      repeat (4) begin
         v = vi(i);
         @(negedge clk);
         chk("level value", follow ? v : v0, vo(i));
      end
      @(posedge clk);
      prog.hold(i, 1'b0, 1'b0);
      @(posedge clk);
   endtask : level_run

   // about 310 cycles are needed; the ceiling leaves ample margin
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         miscompares++;
         print_verdict();
      end
   end

   // every rising confirm takes the oldest expected transfer off the queue
   always @(negedge clk) begin
      for (int i = 0; i < 32; i++)
         if (rstn && transfer_confirm[i] && !prev_conf[i]) begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : '1;
            chk("confirmed element", 32'(e[36:32]), 32'(i));
            chk("held value", e[31:0], vo(i));
         end
      prev_conf <= transfer_confirm;
   end

   initial begin
      seed = 56;
      rstn = 1'b0;
      run_mode = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      chk("confirm at reset", 32'h0000_0000, transfer_confirm);
      for (int i = 0; i < 32; i++) chk("value at reset", 32'h0000_0000, vo(i));
      $display("test reset done");
      @(posedge clk);
      // four registers, then one unmapped and one unaligned address
      for (int j = 0; j < 6; j++) begin
         apb(1'b0, j < 4 ? 12'(4 * j) : j == 4 ? 12'h010 : 12'h002, 32'h0000_0000);
         chk("register read", 32'h0000_0000, rd);
         chk("slave error", 32'(j >= 4), 32'(er));
      end
      apb(1'b1, ethv_pkg::OFS_RETAIN, 32'h0000_0040);
      apb(1'b0, ethv_pkg::OFS_RETAIN, 32'h0000_0000);
      chk("retain mask", 32'h0000_0040, rd);
      $display("test registers done");
      run_mode <= 1'b1;
      repeat (34) @(posedge clk);
      for (int i = 0; i < 32; i++) begin
         vals[i] = i == 0 ? 32'h8000_0000 : i == 1 ? 32'h7fff_ffff : $random(seed);
         exp_q.push_back({5'(i), vals[i]});
         prog.fire(i, vals[i], 3);
         @(negedge clk);
         chk("confirm held", 32'h0000_0001, 32'(transfer_confirm[i]));
         @(negedge clk);
         chk("confirm dropped", 32'h0000_0000, 32'(transfer_confirm[i]));
         chk("value kept", vals[i], vo(i));
         @(posedge clk);
      end
      apb(1'b0, ethv_pkg::OFS_VALUE_LO + 12'h004, 32'h0000_0000);
      chk("value register", vals[1], rd);
      $display("test transfers done");
      level_run(4, 1'b0);
      apb(1'b1, ethv_pkg::OFS_NO_EDGE, 32'h0000_0008);
      level_run(3, 1'b1);
      $display("test level modes done");
      apb(1'b1, ethv_pkg::OFS_EN_GATE, 32'h0000_0001);
      v = $random(seed);
      prog.fire(0, v, 3);
      @(posedge clk);
      chk("gated value", vals[0], vo(0));
      prog.hold(0, 1'b0, 1'b1);
      @(posedge clk);
      exp_q.push_back({5'd0, v});
      prog.fire(0, v, 2);
      repeat (2) @(posedge clk);
      $display("test gating done");
      run_mode <= 1'b0;
      @(posedge clk);
      prog.fire(6, 32'h1234_5678, 3);
      @(posedge clk);
      chk("value in stop", vals[6], vo(6));
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      // power loss also clears the configuration, so the mask is set again
      apb(1'b1, ethv_pkg::OFS_RETAIN, 32'h0000_0040);
      run_mode <= 1'b1;
      repeat (34) @(posedge clk);
      chk("restored value", vals[6], vo(6));
      chk("non-retained value", 32'h0000_0000, vo(7));
      $display("test retention done");
      chk("pending transfers", 32'h0000_0000, 32'(exp_q.size()));
      print_verdict();
   end
endmodule : tb_edge_triggered_value_hold
